// *** acs_top.v ***
// Purpose: Audio serial port clock selection: registers on Avalon-MM and the clock paths they steer
// Assumes: 125 MHz sys_clk_i; audio sources are slow pins sampled through two flip-flops
// Notes:   Summary of operation below; clocks are rebuilt as levels on sys_clk_i
//
// Summary of operation
// R1 - Upper-half mask bits enable lower-half writes
// R2 - Fraction register: high numerator, low denominator
// R3 - Port 1 transmit fraction fed by integer clock
// R4 - Port 1 receive fraction fed by integer clock
// R5 - Port 1 master out: chooser or halved oscillator
// R6 - Port 2 master out: chooser or halved oscillator
// R7 - Source and PLL codes; code three reserved
//
// Register map, byte offsets
// 0x1e0 port 1 transmit select
// 0x1e4 port 1 transmit fraction
// 0x1e8 port 1 receive select
// 0x1ec port 1 receive fraction
// 0x1f0 port 2 transmit select
// 0x300 status, read only
//
// Select register fields
// 31:16 write mask, reads zero
// 15 master out choice, transmit selects only
// 12 path chooser
// 11:10 path source
// 9:8 PLL choice
// 6:0 divisor minus one
// Other bits read zero
//
// Fraction register fields
// 31:16 numerator
// 15:0 denominator
// Zero denominator holds low
// Keep numerator <= half the denominator
// Fraction output is high one integer period
// per accumulator overflow
//
// Status bits
// 4 port 1 transmit clock
// 3 port 1 receive clock
// 2 port 1 master clock
// 1 port 2 transmit clock
// 0 port 2 master clock
//
// Limitations
// Clocks are levels on sys_clk_i
// Sources run far below sys_clk_i
// Switching is not glitch-free
// Port 2 fraction path is idle
// One wait cycle per request
// Pin to output takes a few cycles
// Reserved source code gives a low clock; reserved PLL code stalls the dividers
// Receive chooser 1 takes transmit
// Halved oscillator toggles per edge
// Divisor change acts at next edge
// Reset: 0x111, 0, 0x13, 0, 0x111
// Byte enables mask fraction lanes
// Mask lanes need their byte enables
`timescale 1ns/1ps
`include "acs_regs.vh"

module acs_top (
    input wire sys_clk_i,
    input wire reset_i,

    // Register bus
    input wire [11:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,

    // Source pins, asynchronous
    input wire audio_pll_a_i,
    input wire audio_pll_b_i,
    input wire crystal_oscillator_i,
    input wire port1_tx_external_master_i,
    input wire port1_rx_external_master_i,
    input wire port2_tx_external_master_i,
    input wire port2_rx_clk_i,

    // Clock levels, all registered
    output reg port1_tx_clk_o,
    output reg port1_rx_clk_o,
    output reg port1_master_clk_o,
    output reg port2_tx_clk_o,
    output reg port2_master_clk_o
);

    // ****************************************
    // Registers
    // ****************************************
    reg [15:0] p1_tx_sel_reg;
    reg [31:0] p1_tx_frac_reg;
    reg [15:0] p1_rx_sel_reg;
    reg [31:0] p1_rx_frac_reg;
    reg [15:0] p2_tx_sel_reg;

    // Bus helpers
    reg [31:0] rd_next;
    wire [31:0] lane_mask;
    wire [15:0] wr_mask;
    wire wr_go;

    // Expand byte enables to a bit mask
    assign lane_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                        {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // Mask half only counts where its byte lanes are enabled
    assign wr_mask = avs_writedata_i[`ACS_MASK_HI:`ACS_MASK_LO] & lane_mask[31:16];
    // A write lands at the edge where waitrequest is seen low
    assign wr_go = avs_write_i && !avs_waitrequest_o;

    // Masked update of a selection register; unmasked and reserved bits keep their value
    // Reserved bits read zero
    function [15:0] masked_write;
        input [15:0] old;
        input [15:0] data;
        input [15:0] mask;
        input [15:0] writable;
        begin
            masked_write = (old & ~(mask & writable)) | (data & mask & writable); // see R1
        end
    endfunction

    // ****************************************
    // Bus slave
    // ****************************************
    // Every request waits exactly one cycle; waitrequest comes from a flop so the master sees no glitch
    // Read data holds until next read
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                avs_readdata_o <= rd_next;
            end
        end
    end

    // Read decode; write-only mask half reads zero, unmapped addresses read zero
    // Status sampled at the take
    always @* begin
        case (avs_address_i)
            `ACS_OFF_P1_TX_SEL: rd_next = {16'h0000, p1_tx_sel_reg};
            `ACS_OFF_P1_TX_FRAC: rd_next = p1_tx_frac_reg;
            `ACS_OFF_P1_RX_SEL: rd_next = {16'h0000, p1_rx_sel_reg};
            `ACS_OFF_P1_RX_FRAC: rd_next = p1_rx_frac_reg;
            `ACS_OFF_P2_TX_SEL: rd_next = {16'h0000, p2_tx_sel_reg};
            `ACS_OFF_STATUS: rd_next = {27'h0000000, port1_tx_clk_o, port1_rx_clk_o,
                                        port1_master_clk_o, port2_tx_clk_o, port2_master_clk_o};
            default: rd_next = 32'h00000000;
        endcase
    end

    // Register writes
    // Others change nothing
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            p1_tx_sel_reg <= `ACS_RST_P1_TX_SEL;
            p1_tx_frac_reg <= `ACS_RST_FRAC;
            p1_rx_sel_reg <= `ACS_RST_P1_RX_SEL;
            p1_rx_frac_reg <= `ACS_RST_FRAC;
            p2_tx_sel_reg <= `ACS_RST_P2_TX_SEL;
        end else if (wr_go) begin
            case (avs_address_i)
                `ACS_OFF_P1_TX_SEL: p1_tx_sel_reg <= masked_write(p1_tx_sel_reg, avs_writedata_i[15:0],
                                                                  wr_mask, `ACS_TX_WRITABLE); // see R1
                `ACS_OFF_P1_RX_SEL: p1_rx_sel_reg <= masked_write(p1_rx_sel_reg, avs_writedata_i[15:0],
                                                                  wr_mask, `ACS_RX_WRITABLE); // see R1
                `ACS_OFF_P2_TX_SEL: p2_tx_sel_reg <= masked_write(p2_tx_sel_reg, avs_writedata_i[15:0],
                                                                  wr_mask, `ACS_TX_WRITABLE); // see R1
                // Fraction registers have no mask half; byte enables select lanes
                `ACS_OFF_P1_TX_FRAC: p1_tx_frac_reg <= (p1_tx_frac_reg & ~lane_mask) |
                                                       (avs_writedata_i & lane_mask); // see R2
                `ACS_OFF_P1_RX_FRAC: p1_rx_frac_reg <= (p1_rx_frac_reg & ~lane_mask) |
                                                       (avs_writedata_i & lane_mask); // see R2
                default: p1_tx_frac_reg <= p1_tx_frac_reg;
            endcase
        end
    end

    // ****************************************
    // Input synchronisers and edge detection
    // ****************************************
    // Bit order: 0 pll_a, 1 pll_b, 2 osc, 3 p1 tx ext, 4 p1 rx ext, 5 p2 tx ext, 6 p2 rx clk
    reg [6:0] sync1_reg;
    reg [6:0] sync2_reg;
    reg [6:0] prev_reg;
    reg osc_half_reg;
    wire [6:0] rise;

    // Stage one is read only by stage two; edges compare stage two with a third flop
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
            prev_reg <= 7'h00;
        end else begin
            sync1_reg <= {port2_rx_clk_i, port2_tx_external_master_i, port1_rx_external_master_i,
                          port1_tx_external_master_i, crystal_oscillator_i, audio_pll_b_i, audio_pll_a_i};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Only rising edges count
    assign rise = sync2_reg & ~prev_reg;

    // Halved oscillator toggles on each oscillator rising edge
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            osc_half_reg <= 1'b0;
        end else if (rise[2]) begin
            osc_half_reg <= !osc_half_reg;
        end
    end

    // ****************************************
    // Clock paths
    // ****************************************
    wire p1_tx_path;
    wire p1_rx_path;
    wire p2_tx_path;

    // Port 1 transmit
    acs_path u_p1_tx (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pll_level_i(sync2_reg[2:0]),
        .pll_rise_i(rise[2:0]),
        .ext_level_i(sync2_reg[3]),
        .pll_choice_i(p1_tx_sel_reg[`ACS_PLL_HI:`ACS_PLL_LO]),
        .source_choice_i(p1_tx_sel_reg[`ACS_SRC_HI:`ACS_SRC_LO]),
        .integer_divisor_i(p1_tx_sel_reg[`ACS_DIV_HI:`ACS_DIV_LO]),
        .fraction_ratio_i(p1_tx_frac_reg),
        .int_clk_o(),
        .frac_clk_o(),
        .path_clk_o(p1_tx_path)
    ); // see R3

    // Port 1 receive
    acs_path u_p1_rx (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pll_level_i(sync2_reg[2:0]),
        .pll_rise_i(rise[2:0]),
        .ext_level_i(sync2_reg[4]),
        .pll_choice_i(p1_rx_sel_reg[`ACS_PLL_HI:`ACS_PLL_LO]),
        .source_choice_i(p1_rx_sel_reg[`ACS_SRC_HI:`ACS_SRC_LO]),
        .integer_divisor_i(p1_rx_sel_reg[`ACS_DIV_HI:`ACS_DIV_LO]),
        .fraction_ratio_i(p1_rx_frac_reg),
        .int_clk_o(),
        .frac_clk_o(),
        .path_clk_o(p1_rx_path)
    ); // see R4

    // Port 2 transmit has no fraction register in this block, so its fraction path stays idle
    acs_path u_p2_tx (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pll_level_i(sync2_reg[2:0]),
        .pll_rise_i(rise[2:0]),
        .ext_level_i(sync2_reg[5]),
        .pll_choice_i(p2_tx_sel_reg[`ACS_PLL_HI:`ACS_PLL_LO]),
        .source_choice_i(p2_tx_sel_reg[`ACS_SRC_HI:`ACS_SRC_LO]),
        .integer_divisor_i(p2_tx_sel_reg[`ACS_DIV_HI:`ACS_DIV_LO]),
        .fraction_ratio_i(`ACS_RST_FRAC),
        .int_clk_o(),
        .frac_clk_o(),
        .path_clk_o(p2_tx_path)
    );

    // ****************************************
    // Path choosers and master-clock outputs
    // ****************************************
    // All outputs registered; mux switching is not glitch-free, a known limit of this level model
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            port1_tx_clk_o <= 1'b0;
            port1_rx_clk_o <= 1'b0;
            port1_master_clk_o <= 1'b0;
            port2_tx_clk_o <= 1'b0;
            port2_master_clk_o <= 1'b0;
        end else begin
            port1_tx_clk_o <= p1_tx_sel_reg[`ACS_CHOOSER_BIT] ? p1_rx_path : p1_tx_path; // see R5
            port1_rx_clk_o <= p1_rx_sel_reg[`ACS_CHOOSER_BIT] ? p1_tx_path : p1_rx_path;
            port1_master_clk_o <= p1_tx_sel_reg[`ACS_OUT_CHOICE_BIT] ? osc_half_reg :
                                  (p1_tx_sel_reg[`ACS_CHOOSER_BIT] ? p1_rx_path : p1_tx_path); // see R5

            // Port 2 chooser takes the pin
            port2_tx_clk_o <= p2_tx_sel_reg[`ACS_CHOOSER_BIT] ? sync2_reg[6] : p2_tx_path; // see R6
            port2_master_clk_o <= p2_tx_sel_reg[`ACS_OUT_CHOICE_BIT] ? osc_half_reg :
                                  (p2_tx_sel_reg[`ACS_CHOOSER_BIT] ? sync2_reg[6] : p2_tx_path); // see R6
        end
    end

endmodule // acs_top

// *** acs_regs.vh ***
// Purpose: Offsets, fields, reset values and bus constants for the audio clock select block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Definitions only
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ACS_ADDR_W 12
`define ACS_OFF_P1_TX_SEL 12'h1e0
`define ACS_OFF_P1_TX_FRAC 12'h1e4
`define ACS_OFF_P1_RX_SEL 12'h1e8
`define ACS_OFF_P1_RX_FRAC 12'h1ec
`define ACS_OFF_P2_TX_SEL 12'h1f0
`define ACS_OFF_STATUS 12'h300

// ****************************************
// Selection and fraction register fields
// ****************************************
`define ACS_MASK_HI 31
`define ACS_MASK_LO 16
`define ACS_OUT_CHOICE_BIT 15
`define ACS_CHOOSER_BIT 12
`define ACS_SRC_HI 11
`define ACS_SRC_LO 10
`define ACS_PLL_HI 9
`define ACS_PLL_LO 8
`define ACS_DIV_HI 6
`define ACS_DIV_LO 0
`define ACS_FRAC_NUM_HI 31
`define ACS_FRAC_NUM_LO 16
`define ACS_FRAC_DEN_HI 15
`define ACS_FRAC_DEN_LO 0

// Writable lower-half bits of each selection register
`define ACS_TX_WRITABLE 16'h9f7f
`define ACS_RX_WRITABLE 16'h1f7f

// ****************************************
// Reset values
// ****************************************
`define ACS_RST_P1_TX_SEL 16'h0111
`define ACS_RST_P1_RX_SEL 16'h0013
`define ACS_RST_P2_TX_SEL 16'h0111
`define ACS_RST_FRAC 32'h00000000

// ****************************************
// Field codes
// ****************************************
`define ACS_SRC_INT 2'h0
`define ACS_SRC_FRAC 2'h1
`define ACS_SRC_EXT 2'h2
`define ACS_PLL_A 2'h0
`define ACS_PLL_B 2'h1
`define ACS_PLL_OSC 2'h2

`endif

// *** acs_path.v ***
// Purpose: One audio clock path: source pick, integer divider, fractional divider, output pick
// Assumes: Source levels and edges are already synchronised to sys_clk_i
// Notes:   Output clocks are levels rebuilt on sys_clk_i, so sources must run well below it
`timescale 1ns/1ps
`include "acs_regs.vh"

module acs_path (
    input wire sys_clk_i,
    input wire reset_i,
    input wire [2:0] pll_level_i,
    input wire [2:0] pll_rise_i,
    input wire ext_level_i,
    input wire [1:0] pll_choice_i,
    input wire [1:0] source_choice_i,
    input wire [6:0] integer_divisor_i,
    input wire [31:0] fraction_ratio_i,
    output reg int_clk_o,
    output reg frac_clk_o,
    output reg path_clk_o
);

    // Three-way pick on a two-bit code; code 3 is reserved and yields low
    function pick3;
        input [1:0] code;
        input [2:0] vec;
        begin
            case (code)
                2'h0: pick3 = vec[0];
                2'h1: pick3 = vec[1];
                2'h2: pick3 = vec[2];
                default: pick3 = 1'b0;
            endcase
        end
    endfunction

    reg [6:0] cnt_reg;
    reg [16:0] acc_reg;
    wire src_rise;
    wire src_level;
    wire int_tick;
    wire [15:0] num;
    wire [15:0] den;
    wire [16:0] acc_sum;
    wire overflow;
    wire [16:0] acc_next;

    // ****************************************
    // PLL pick and integer divider
    // ****************************************
    assign src_rise = pick3(pll_choice_i, pll_rise_i); // see R7
    assign src_level = pick3(pll_choice_i, pll_level_i); // see R7
    // A divisor lowered below the count wraps at the next edge instead of running on to 127
    assign int_tick = src_rise && (cnt_reg >= integer_divisor_i);

    // Count source edges modulo divisor+1; level high for the first half of each period
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= 7'h00;
            int_clk_o <= 1'b0;
        end else begin
            if (src_rise) begin
                cnt_reg <= int_tick ? 7'h00 : cnt_reg + 7'h01; // see R3, R4
            end
            if (integer_divisor_i == 7'h00) begin
                int_clk_o <= src_level; // Divide by one passes the source through
            end else if (src_rise) begin
                int_clk_o <= ({1'b0, (int_tick ? 7'h00 : cnt_reg + 7'h01)} << 1) <=
                             {1'b0, integer_divisor_i}; // see R3, R4
            end
        end
    end

    // ****************************************
    // Fractional divider fed by the integer clock
    // ****************************************
    assign num = fraction_ratio_i[`ACS_FRAC_NUM_HI:`ACS_FRAC_NUM_LO]; // see R2
    assign den = fraction_ratio_i[`ACS_FRAC_DEN_HI:`ACS_FRAC_DEN_LO]; // see R2
    assign acc_sum = acc_reg + {1'b0, num};
    assign overflow = (den != 16'h0000) && (acc_sum >= {1'b0, den});
    assign acc_next = overflow ? acc_sum - {1'b0, den} : acc_sum;

    // Each integer tick adds num; crossing den yields one output period, so rate = integer clock rate*num/den
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_reg <= 17'h00000;
            frac_clk_o <= 1'b0;
        end else if (int_tick) begin
            acc_reg <= (den == 16'h0000) ? 17'h00000 : acc_next; // see R2, R3, R4
            frac_clk_o <= overflow; // A zero denominator holds the output low
        end
    end

    // ****************************************
    // Output source pick
    // ****************************************
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            path_clk_o <= 1'b0;
        end else begin
            path_clk_o <= pick3(source_choice_i, {ext_level_i, frac_clk_o, int_clk_o}); // see R7
        end
    end

endmodule // acs_path

// *** acs_top_chk.sv ***
// Purpose: Bus-side checks for the audio clock select block
// Assumes: Sees only the ports of acs_top
// Notes:   Clock rates are judged by the bench, not here
`timescale 1ns/1ps
`include "acs_regs.vh"

// ****************************************
// Checker
// ****************************************
module acs_top_chk (
    input wire sys_clk_i,
    input wire reset_i,
    input wire [11:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    // Address decode mirrors the register map
    wire is_tx = (avs_address_i == `ACS_OFF_P1_TX_SEL) || (avs_address_i == `ACS_OFF_P2_TX_SEL);
    wire is_rx = avs_address_i == `ACS_OFF_P1_RX_SEL;
    wire is_st = avs_address_i == `ACS_OFF_STATUS;
    wire is_fr = (avs_address_i == `ACS_OFF_P1_TX_FRAC) || (avs_address_i == `ACS_OFF_P1_RX_FRAC);
    wire rd_take = avs_read_i && avs_waitrequest_o;

    // A taken request gets exactly one low cycle of waitrequest
    sequence s_take;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    take_answer_a: assert property (s_take |=> s_answer)
        else $error("request not answered after one wait cycle");
    idle_wait_a: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest dropped without a request");
    unmapped_zero_a: assert property (rd_take && !(is_tx || is_rx || is_st || is_fr) |=> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    sel_upper_a: assert property (rd_take && (is_tx || is_rx) |=> avs_readdata_o[31:16] == 16'h0)
        else $error("mask half of select register reads nonzero");
    tx_reserved_a: assert property (rd_take && is_tx |=> (avs_readdata_o[15:0] & ~`ACS_TX_WRITABLE) == 16'h0)
        else $error("reserved bit set in transmit select");
    rx_reserved_a: assert property (rd_take && is_rx |=> (avs_readdata_o[15:0] & ~`ACS_RX_WRITABLE) == 16'h0)
        else $error("reserved bit set in receive select");
    status_bits_a: assert property (rd_take && is_st |=> avs_readdata_o[31:5] == 27'h0)
        else $error("status upper bits nonzero");
    data_hold_a: assert property (!rd_take |=> $stable(avs_readdata_o))
        else $error("read data moved without a read");
endmodule // acs_top_chk

// *** acs_top_bench.sv ***
// Purpose: Self-checking bench for the audio clock select block
// Assumes: Sources come from one free counter, so each rate is exact
// Notes:   Rates are counted over a window with one and a half edges of slack
`timescale 1ns/1ps
`include "acs_regs.vh"

module acs_top_bench;
    // ****************************************
    // Stimulus and design
    // ****************************************
    reg sys_clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg [11:0] avs_address_i = 12'h000;
    reg avs_read_i = 1'b0;
    reg avs_write_i = 1'b0;
    reg [3:0] avs_byteenable_i = 4'hf;
    reg [31:0] avs_writedata_i = 32'h0;
    reg [8:0] src_cnt = 9'h000;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o;
    wire [4:0] outs;
    integer err_count = 0;
    integer cmp_count = 0;
    integer cnt [0:4];
    reg [15:0] sh [0:2];
    reg [11:0] offs [0:2];
    reg [31:0] fr [0:1];
    reg [31:0] q, d;
    reg [11:0] fa;
    reg [3:0] be;
    reg [1:0] s, p;
    integer k, r;

    // Clock at 125 MHz
    always #4 sys_clk_i = ~sys_clk_i;
    // Power-of-two sources keep every expected edge count whole except after a divide by three
    always @(posedge sys_clk_i) src_cnt <= src_cnt + 9'h001;

    acs_top i_dut (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .audio_pll_a_i(src_cnt[3]),
        .audio_pll_b_i(src_cnt[4]),
        .crystal_oscillator_i(src_cnt[5]),
        .port1_tx_external_master_i(src_cnt[6]),
        .port1_rx_external_master_i(src_cnt[7]),
        .port2_tx_external_master_i(src_cnt[6]),
        .port2_rx_clk_i(src_cnt[8]),
        .port1_tx_clk_o(outs[4]),
        .port1_rx_clk_o(outs[3]),
        .port1_master_clk_o(outs[2]),
        .port2_tx_clk_o(outs[1]),
        .port2_master_clk_o(outs[0])
    );

    // ****************************************
    // Tasks and models
    // ****************************************
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask

    task chk_val(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0t register got %h want %h", $time, got, exp);
            end
        end
    endtask

    task chk_rate(input integer got, input real exp);
        begin
            cmp_count = cmp_count + 1;
            if (got - exp > 1.5 || exp - got > 1.5) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0t edges got %0d want %0f", $time, got, exp);
            end
        end
    endtask

    // Request is held until waitrequest is seen low at a rising edge
    task bus(input wr, input [11:0] a, input [31:0] dt, input [3:0] ben, output [31:0] rq);
        integer n;
        begin
            n = 0;
            @(posedge sys_clk_i);
            avs_address_i <= a;
            avs_writedata_i <= dt;
            avs_byteenable_i <= ben;
            avs_write_i <= wr;
            avs_read_i <= !wr;
            @(posedge sys_clk_i);
            while (avs_waitrequest_o !== 1'b0 && n < 40) begin
                @(posedge sys_clk_i);
                n = n + 1;
            end
            rq = avs_readdata_o;
            avs_write_i <= 1'b0;
            avs_read_i <= 1'b0;
            if (n >= 40) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0t bus gave no answer", $time);
            end
        end
    endtask

    // Masked update of a select register
    function [15:0] sel_next(input [15:0] old, input [31:0] dt, input [15:0] wbl);
        reg [15:0] m;
        begin
            m = dt[31:16] & wbl;
            sel_next = (old & ~m) | (dt[15:0] & m);
        end
    endfunction

    // Expected rising edges in 1024 cycles; fraction is set to one half
    function real rate(input [1:0] sc, input [1:0] pc, input integer dv, input integer ext, input integer fok);
        real b;
        begin
            b = (pc == 2'h0) ? 64.0 : (pc == 2'h1) ? 32.0 : (pc == 2'h2) ? 16.0 : 0.0;
            b = b / (dv + 1);
            rate = (sc == 2'h0) ? b : (sc == 2'h1) ? b * fok / 2.0 : (sc == 2'h2) ? ext : 0.0;
        end
    endfunction

    // Settling time covers the sync and divider pipeline
    task measure;
        integer i, t;
        reg [4:0] prev;
        begin
            repeat (24) @(posedge sys_clk_i);
            for (i = 0; i < 5; i = i + 1) cnt[i] = 0;
            prev = outs;
            for (t = 0; t < 1024; t = t + 1) begin
                @(posedge sys_clk_i);
                for (i = 0; i < 5; i = i + 1) if (outs[i] && !prev[i]) cnt[i] = cnt[i] + 1;
                prev = outs;
            end
        end
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        err_count = err_count + 1;
        $display("CHECK FAILED %0t watchdog expired", $time);
        end_of_test;
    end

    initial begin
        offs[0] = `ACS_OFF_P1_TX_SEL;
        offs[1] = `ACS_OFF_P1_RX_SEL;
        offs[2] = `ACS_OFF_P2_TX_SEL;
        sh[0] = `ACS_RST_P1_TX_SEL;
        sh[1] = `ACS_RST_P1_RX_SEL;
        sh[2] = `ACS_RST_P2_TX_SEL;
        fr[0] = `ACS_RST_FRAC;
        fr[1] = `ACS_RST_FRAC;
        k = $urandom(92106);
        repeat (12) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        for (r = 0; r < 3; r = r + 1) begin
            bus(1'b0, offs[r], 32'h0, 4'hf, q);
            chk_val(q, {16'h0, sh[r]});
        end
        // Masked writes: all set, mask clear, then random
        for (k = 0; k < 36; k = k + 1) begin
            r = k % 3;
            d = (k < 3) ? 32'hffffffff : (k < 6) ? 32'h0000ffff : $urandom;
            bus(1'b1, offs[r], d, 4'hf, q);
            sh[r] = sel_next(sh[r], d, (r == 1) ? `ACS_RX_WRITABLE : `ACS_TX_WRITABLE);
            bus(1'b0, offs[r], 32'h0, 4'hf, q);
            chk_val(q, {16'h0, sh[r]});
        end
        // Fraction registers with random byte lanes
        for (k = 0; k < 16; k = k + 1) begin
            r = k % 2;
            fa = r ? `ACS_OFF_P1_RX_FRAC : `ACS_OFF_P1_TX_FRAC;
            d = $urandom;
            q = $urandom;
            be = (k < 2) ? 4'hf : q[3:0];
            bus(1'b0, fa, 32'h0, 4'hf, q);
            chk_val(q, fr[r]);
            bus(1'b1, fa, d, be, q);
            for (p = 0; p < 3; p = p + 1) if (be[p]) fr[r][p*8 +: 8] = d[p*8 +: 8];
            if (be[3]) fr[r][31:24] = d[31:24];
        end
        bus(1'b1, 12'h1f4, 32'h12345678, 4'hf, q);
        bus(1'b0, 12'h1f4, 32'h0, 4'hf, q);
        chk_val(q, 32'h0);
        bus(1'b0, `ACS_OFF_STATUS, 32'h0, 4'hf, q);
        chk_val(q & 32'hffffffe0, 32'h0);
        // Every source and PLL code, with one half as the fraction
        bus(1'b1, `ACS_OFF_P1_TX_FRAC, 32'h00010002, 4'hf, q);
        bus(1'b1, `ACS_OFF_P1_RX_FRAC, 32'h00010002, 4'hf, q);
        for (k = 0; k < 16; k = k + 1) begin
            s = k[3:2];
            p = k[1:0];
            d = {16'hffff, 4'h0, s, p, 8'h0} | (k % 3);
            for (r = 0; r < 3; r = r + 1) bus(1'b1, offs[r], d, 4'hf, q);
            measure;
            chk_rate(cnt[4], rate(s, p, k % 3, 8, 1));
            chk_rate(cnt[2], rate(s, p, k % 3, 8, 1));
            chk_rate(cnt[3], rate(s, p, k % 3, 4, 1));
            chk_rate(cnt[1], rate(s, p, k % 3, 8, 0));
            chk_rate(cnt[0], rate(s, p, k % 3, 8, 0));
        end
        // Chooser set to the receive side
        bus(1'b1, offs[1], 32'hffff0000, 4'hf, q);
        bus(1'b1, offs[0], 32'h10001000, 4'hf, q);
        bus(1'b1, offs[2], 32'h10001000, 4'hf, q);
        measure;
        chk_rate(cnt[2], 64.0);
        chk_rate(cnt[0], 2.0);
        // Halved oscillator on both master outputs
        bus(1'b1, offs[0], 32'h80008000, 4'hf, q);
        bus(1'b1, offs[2], 32'h80008000, 4'hf, q);
        measure;
        chk_rate(cnt[2], 8.0);
        chk_rate(cnt[0], 8.0);
        end_of_test;
    end
endmodule // acs_top_bench

bind acs_top acs_top_chk i_chk (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o)
);
